// >>> dv/host_model.sv
`timescale 1ns/10ps
module host_model import tx_codec_pkg::*; (
  // Clock and character timing from the device
  input  wire logic  sys_clk,
  input  wire logic  char_strobe,
  // Character toward the device
  output tx_char_in_t tx_in
);
  initial tx_in = IN_RESET;

  // Present one character for the next strobe edge, then scramble the bus.
  // Sampling off the strobe edge would then show up as a wrong character.
  task automatic put(input tx_char_in_t c);
    int n;
    n = 0;
    while (char_strobe !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    tx_in = c;
    @(negedge sys_clk);
    tx_in = ~c;
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/10ps
module tb_top import tx_codec_pkg::*;;
  logic        sys_clk;
  logic        rstn;
  level_t      par_sel;
  level_t      mode_hi;
  level_t      mode_lo;
  logic        alt_tbl;
  logic        pab_err;
  logic        bist_en;
  tx_char_in_t tx_in;
  logic        char_strobe;
  logic [9:0]  tx_char;
  logic        ser_out;
  logic        err_flag;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;

  // K28.5 in both forms, D0.0 from negative disparity, both violation forms
  localparam logic [9:0] K_NEG    = 10'h17C;
  localparam logic [9:0] K_POS    = 10'h283;
  localparam logic [9:0] D00_NEG  = 10'h0B9;
  localparam logic [9:0] VIOL_P   = 10'h079;
  localparam logic [9:0] VIOL_N   = 10'h386;
  localparam logic [9:0] SER_CHAR = 10'h2B5;
  // D0.0 from positive disparity, D31.7 and D30.7 from negative disparity
  localparam logic [9:0] D00_POS  = 10'h346;
  localparam logic [9:0] BIST_FF  = 10'h235;
  localparam logic [9:0] BIST_FE  = 10'h21E;

  tx_parity_check_encoder_select u_dut (
    .SYS_CLK             (sys_clk),
    .RSTN                (rstn),
    .PARITY_CHECK_SELECT (par_sel),
    .TX_MODE_SELECT_HI   (mode_hi),
    .TX_MODE_SELECT_LO   (mode_lo),
    .ALT_CODE_TABLE      (alt_tbl),
    .BIST_ENABLE         (bist_en),
    .TX_IN               (tx_in),
    .CHAR_STROBE         (char_strobe),
    .PAB_ERROR           (pab_err),
    .TX_CHAR             (tx_char),
    .SER_OUT             (ser_out),
    .TX_ERROR_FLAG       (err_flag)
  );

  host_model u_host (
    .sys_clk     (sys_clk),
    .char_strobe (char_strobe),
    .tx_in       (tx_in)
  );

  // 100 ns bit clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic cmp_char(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset with a new static setup; outputs are judged while reset is held
  task automatic set_cfg(input level_t p, input level_t hi, input level_t lo, input logic alt);
    @(negedge sys_clk);
    rstn = 1'b0;
    par_sel = p;
    mode_hi = hi;
    mode_lo = lo;
    alt_tbl = alt;
    repeat (6) @(negedge sys_clk);
    cmp_char("tx_char in reset", 10'h000, tx_char);
    cmp_bit("char_strobe in reset", 1'b0, char_strobe);
    cmp_bit("tx_error_flag in reset", 1'b0, err_flag);
    rstn = 1'b1;
  endtask

  // Hand over one character; the slot starting at that edge belongs to the previous one
  task automatic xfer(input tx_char_in_t c, input logic [9:0] exp, input logic exp_err);
    u_host.put(c);
    cmp_char("tx_char", exp, tx_char);
    cmp_bit("tx_error_flag", exp_err, err_flag);
  endtask

  // Word sync forms: chars two and three reversed, then plain alternation
  function automatic logic [9:0] ws_form(input int i);
    if (i < 2) return K_NEG;
    if (i < 4) return K_POS;
    return (i % 2 == 0) ? K_NEG : K_POS;
  endfunction

  // Cycle ceiling well above the roughly 600 cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    tx_char_in_t tbl [5];
    tx_char_in_t c;
    level_t      sels [3];
    logic [9:0]  prev;
    logic        prev_err;
    logic        bad;
    tbl = '{12'h001, 12'h401, 12'h700, 12'h300, 12'hEB5};
    sels = '{LVL_LOW, LVL_MID, LVL_HIGH};
    rstn = 1'b0;
    par_sel = LVL_LOW;
    mode_hi = LVL_LOW;
    mode_lo = LVL_HIGH;
    alt_tbl = 1'b0;
    pab_err = 1'b0;
    bist_en = 1'b0;
    // Bypass: raw characters, parity over all eleven bits unless select is low
    foreach (sels[s]) begin
      set_cfg(sels[s], LVL_LOW, LVL_HIGH, 1'b0);
      prev = 10'h000;
      prev_err = 1'b0;
      foreach (tbl[i]) begin
        c = tbl[i];
        xfer(c, prev, prev_err);
        bad = (sels[s] != LVL_LOW) && !(^{c.tx_parity_bit, c.tx_control_bits, c.tx_data_bits});
        prev = bad ? VIOL_P : {c.tx_control_bits, c.tx_data_bits};
        prev_err = bad;
      end
      xfer(tbl[0], prev, prev_err);
      // Serial order of the last character, first line bit first
      for (int k = 0; k < 10; k++) begin
        cmp_bit("ser_out", SER_CHAR[k], ser_out);
        if (k < 9) @(negedge sys_clk);
      end
    end
    // Encoded, parity over data bits only, disparity held through violations
    set_cfg(LVL_MID, LVL_HIGH, LVL_HIGH, 1'b0);
    xfer(12'h1BC, D00_NEG, 1'b0);
    xfer(12'h5BC, K_NEG, 1'b0);
    xfer(12'h1BC, VIOL_P, 1'b1);
    pab_err = 1'b1;
    xfer(12'h1BC, VIOL_P, 1'b1);
    pab_err = 1'b0;
    xfer(12'h1BC, K_POS, 1'b0);
    xfer(12'h1BC, K_NEG, 1'b0);
    // Encoded, parity also over control bits, reduced special table
    set_cfg(LVL_HIGH, LVL_HIGH, LVL_HIGH, 1'b1);
    xfer(12'h1BC, D00_NEG, 1'b0);
    xfer(12'h200, VIOL_N, 1'b1);
    xfer(12'h5BC, K_NEG, 1'b0);
    xfer(12'h5BC, K_POS, 1'b0);
    // Self-test: seed character first, host input and its bad parity ignored
    set_cfg(LVL_MID, LVL_HIGH, LVL_HIGH, 1'b0);
    bist_en = 1'b1;
    xfer(12'h000, BIST_FF, 1'b0);
    xfer(12'h000, BIST_FE, 1'b0);
    bist_en = 1'b0;
    // Interruptible word sync under special select, cut short by a parity error
    set_cfg(LVL_MID, LVL_HIGH, LVL_MID, 1'b0);
    xfer(12'hD00, D00_NEG, 1'b0);
    xfer(12'h400, K_NEG, 1'b0);
    xfer(12'h000, K_NEG, 1'b0);
    xfer(12'h400, VIOL_P, 1'b1);
    xfer(12'h400, D00_POS, 1'b0);
    // Atomic word sync: fifteen following characters ignored, bad parity and all
    set_cfg(LVL_MID, LVL_MID, LVL_LOW, 1'b0);
    xfer(12'h700, D00_NEG, 1'b0);
    for (int i = 0; i < 16; i++) begin
      xfer((i < 15) ? 12'h055 : 12'h1BC, ws_form(i), 1'b0);
    end
    xfer(12'h1BC, K_NEG, 1'b0);
    print_verdict();
  end
endmodule

// >>> hdl/enc_8b10b.sv
`timescale 1ns/10ps
module enc_8b10b import tx_codec_pkg::*; (
  // Character and running disparity in
  input  wire enc_req_t req,
  // Symbol and disparity out
  output logic [9:0]    code,
  output logic          rd_out
);

  logic [4:0] x;
  logic [2:0] y;
  logic [5:0] six;
  logic [3:0] four;
  logic       rd_mid;
  logic       flip6;
  logic       flip4;
  logic       alt7;
  logic       k28;
  logic [9:0] str;

  // Table lookup, then complement by running disparity
  always_comb begin
    x      = req.data[4:0];
    y      = req.data[7:5];
    k28    = req.is_k && (x == K28_X);
    six    = k28 ? SIX_B_K28 : SIX_B[x];
    flip6  = req.rd && ((count_ones(six) != 3'h3) || (six == SIX_B_D7));
    rd_mid = req.rd ^ (count_ones(six) != 3'h3);
    // Alternate x.7 avoids a run of five equal bits across the boundary
    alt7   = (y == 3'h7) && (req.is_k
             || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
             || (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
    four   = alt7 ? FOUR_B_A7 : FOUR_B[y];
    if (k28 && (count_ones({2'h0, four}) == 3'h2) && (four != FOUR_B_X3)) begin
      flip4 = !rd_mid;
    end else begin
      flip4 = rd_mid && ((count_ones({2'h0, four}) != 3'h2) || (four == FOUR_B_X3));
    end
    rd_out = rd_mid ^ (count_ones({2'h0, four}) != 3'h2);
    str    = {six ^ {6{flip6}}, four ^ {4{flip4}}};
    code   = {<<{str}};
  end

endmodule

// >>> hdl/tx_parity_check_encoder_select.sv
`timescale 1ns/10ps
module tx_parity_check_encoder_select import tx_codec_pkg::*; (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  // Static configuration
  input  wire level_t      PARITY_CHECK_SELECT,
  input  wire level_t      TX_MODE_SELECT_HI,
  input  wire level_t      TX_MODE_SELECT_LO,
  input  wire logic        ALT_CODE_TABLE,
  input  wire logic        BIST_ENABLE,
  // Host character
  input  wire tx_char_in_t TX_IN,
  output logic             CHAR_STROBE,
  // Phase-align buffer status
  input  wire logic        PAB_ERROR,
  // Shifter side
  output logic [9:0]       TX_CHAR,
  output logic             SER_OUT,
  output logic             TX_ERROR_FLAG
);

  logic [3:0]  bit_cnt_r;
  logic        char_en;
  tx_char_in_t in_r;
  logic [9:0]  raw_char;
  logic [9:0]  char_r;
  logic [9:0]  char_nxt;
  logic [9:0]  shift_r;
  logic        err_r;
  logic        err_nxt;
  logic        rd_r;
  logic        rd_nxt;
  ws_state_t   ws_state_r;
  ws_state_t   ws_state_nxt;
  logic [3:0]  ws_idx_r;
  logic [3:0]  ws_idx_nxt;
  logic [3:0]  ws_pos;
  logic [8:0]  lfsr_r;
  logic [8:0]  lfsr_nxt;
  out_sel_t    out_sel;
  enc_req_t    enc_req;
  logic [9:0]  enc_code;
  logic        enc_rd;
  logic        bypass;
  logic        atomic_ws;
  logic        intr_ws;
  logic        ws_run;
  logic        chk_en;
  logic        chk_ctl;
  logic        par_ok;
  logic        par_err;
  logic        ws_req;
  logic        fill_req;
  logic        spec_req;
  logic        ws_continue;

  // Advance the self-test generator, x^9 + x^5 + 1, period 511
  function automatic logic [8:0] lfsr_step(input logic [8:0] s);
    return {s[7:0], s[8] ^ s[4]};
  endfunction

  // Special code lookup in the selected table
  function automatic logic [7:0] special_code(input logic [7:0] d, input logic alt);
    return alt ? REDUCED_SPECIAL[d[2:0]] : d;
  endfunction

  // Bit-rate divider: one character slot every ten clocks
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      bit_cnt_r <= BIT_CNT_RST;
    end else if (char_en) begin
      bit_cnt_r <= BIT_CNT_RST;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  assign char_en     = (bit_cnt_r == BIT_CNT_LAST);
  assign CHAR_STROBE = char_en;   // Host character taken on this edge

  // Input register, parity bit captured with the character
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      in_r <= IN_RESET;
    end else if (char_en) begin
      in_r <= TX_IN;
    end
  end

  assign raw_char = {in_r.tx_control_bits, in_r.tx_data_bits};

  // Mode decode; selects are static so no staging is needed
  always_comb begin
    bypass    = (TX_MODE_SELECT_HI == LVL_LOW);
    atomic_ws = (TX_MODE_SELECT_HI == LVL_MID);
    intr_ws   = (TX_MODE_SELECT_HI == LVL_HIGH);
    ws_run    = (ws_state_r == WS_RUN);
  end

  // Control-bit interpretation per low mode select
  always_comb begin
    ws_req   = 1'b0;
    fill_req = 1'b0;
    spec_req = 1'b0;
    if (TX_MODE_SELECT_LO == LVL_LOW) begin
      ws_req   = (in_r.tx_control_bits == 2'h3);
      fill_req = (in_r.tx_control_bits == 2'h1) && !in_r.special_code_select;
      spec_req = (in_r.tx_control_bits == 2'h1) && in_r.special_code_select;
    end else if (TX_MODE_SELECT_LO == LVL_MID) begin
      ws_req   = in_r.special_code_select && in_r.tx_control_bits[0];
      fill_req = !in_r.special_code_select && (in_r.tx_control_bits == 2'h1);
      spec_req = !in_r.special_code_select && (in_r.tx_control_bits == 2'h3);
    end else begin
      ws_req   = (in_r.tx_control_bits == 2'h3);
      fill_req = (in_r.tx_control_bits == 2'h1);
      spec_req = (in_r.tx_control_bits == 2'h2);
    end
  end

  // Parity check; atomic sequence body is exempt
  always_comb begin
    chk_en  = (PARITY_CHECK_SELECT != LVL_LOW);
    chk_ctl = (PARITY_CHECK_SELECT == LVL_HIGH)
              || ((PARITY_CHECK_SELECT == LVL_MID) && bypass);
    par_ok  = ^{in_r.tx_data_bits, in_r.tx_control_bits & {2{chk_ctl}},
                in_r.tx_parity_bit};
    par_err = chk_en && !par_ok && !(atomic_ws && ws_run && !bypass);
  end

  // Character selection and sequencer next state
  always_comb begin
    out_sel      = OUT_ENC;
    enc_req      = '{data: in_r.tx_data_bits, is_k: 1'b0, rd: rd_r};
    err_nxt      = 1'b0;
    ws_state_nxt = ws_state_r;
    ws_idx_nxt   = ws_idx_r;
    ws_pos       = WS_FIRST_IDX;
    ws_continue  = intr_ws && ws_run && (in_r.tx_control_bits == 2'h0);
    lfsr_nxt     = BIST_ENABLE ? lfsr_r : LFSR_SEED;
    if (PAB_ERROR) begin
      // Continuous violation tells the far end the link is bad
      out_sel      = bypass ? OUT_VIOL_POS : OUT_VIOL_RD;
      err_nxt      = 1'b1;
      ws_state_nxt = WS_IDLE;
    end else if (bypass) begin
      if (par_err) begin
        out_sel = OUT_VIOL_POS;
        err_nxt = 1'b1;
      end else begin
        out_sel = OUT_RAW;
      end
    end else if (BIST_ENABLE) begin
      enc_req.data = lfsr_r[7:0];
      lfsr_nxt     = lfsr_step(lfsr_r);
    end else if (atomic_ws && ws_run) begin
      // Input register ignored until the sixteenth K28.5
      ws_pos       = ws_idx_r;
      enc_req.data = K28_5_CODE;
      enc_req.is_k = 1'b1;
      enc_req.rd   = rd_r ^ ((ws_pos == 4'h1) || (ws_pos == 4'h3));
      ws_state_nxt = (ws_pos == WS_LAST_IDX) ? WS_IDLE : WS_RUN;
      ws_idx_nxt   = ws_pos + 4'h1;
    end else if (par_err) begin
      out_sel      = OUT_VIOL_RD;
      err_nxt      = 1'b1;
      ws_state_nxt = WS_IDLE;
    end else if (ws_continue || ws_req) begin
      ws_pos       = ws_continue ? ws_idx_r : WS_FIRST_IDX;
      enc_req.data = K28_5_CODE;
      enc_req.is_k = 1'b1;
      // Second and third commas reversed: flip the disparity fed in at the second and fourth
      enc_req.rd   = rd_r ^ ((ws_pos == 4'h1) || (ws_pos == 4'h3));
      ws_state_nxt = (ws_pos == WS_LAST_IDX) ? WS_IDLE : WS_RUN;
      ws_idx_nxt   = ws_pos + 4'h1;
    end else if (fill_req) begin
      enc_req.data = K28_5_CODE;
      enc_req.is_k = 1'b1;
      ws_state_nxt = WS_IDLE;
    end else if (spec_req) begin
      enc_req.data = special_code(in_r.tx_data_bits, ALT_CODE_TABLE);
      enc_req.is_k = 1'b1;
      ws_state_nxt = WS_IDLE;
    end else begin
      ws_state_nxt = WS_IDLE;   // Any other character ends an open sequence
    end
  end

  // 8B/10B conversion of data and special codes
  enc_8b10b u_enc (
    .req    (enc_req),
    .code   (enc_code),
    .rd_out (enc_rd)
  );

  // Final symbol and running disparity; violation symbols are balanced
  always_comb begin
    rd_nxt = rd_r;
    case (out_sel)
      OUT_RAW: begin
        char_nxt = raw_char;
      end
      OUT_VIOL_POS: begin
        char_nxt = VIOL_POS;
      end
      OUT_VIOL_RD: begin
        char_nxt = rd_r ? VIOL_POS : ~VIOL_POS;
      end
      default: begin
        char_nxt = enc_code;
        rd_nxt   = enc_rd;
      end
    endcase
  end

  // Output character and error flag move together
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      char_r <= CHAR_RESET;
      err_r  <= 1'b0;
    end else if (char_en) begin
      char_r <= char_nxt;
      err_r  <= err_nxt;
    end
  end

  // Transmit shifter
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      shift_r <= CHAR_RESET;
    end else if (char_en) begin
      shift_r <= char_nxt;
    end else begin
      shift_r <= {1'b0, shift_r[9:1]};
    end
  end

  // Running disparity
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      rd_r <= RD_RESET;
    end else if (char_en) begin
      rd_r <= rd_nxt;
    end
  end

  // Word sync sequencer
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ws_state_r <= WS_IDLE;
      ws_idx_r   <= WS_FIRST_IDX;
    end else if (char_en) begin
      ws_state_r <= ws_state_nxt;
      ws_idx_r   <= ws_idx_nxt;
    end
  end

  // Self-test generator, restarts from the seed whenever disabled
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      lfsr_r <= LFSR_SEED;
    end else if (char_en) begin
      lfsr_r <= lfsr_nxt;
    end
  end

  assign TX_CHAR       = char_r;
  assign SER_OUT       = shift_r[0];
  assign TX_ERROR_FLAG = err_r;

  // Checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  no_check_a: assert property (
    char_en && (PARITY_CHECK_SELECT == LVL_LOW) && !PAB_ERROR |=> !TX_ERROR_FLAG)
    else $error("parity error raised with checking disabled");

  data_only_a: assert property (
    char_en && (PARITY_CHECK_SELECT == LVL_MID) && !bypass && !PAB_ERROR
    && !BIST_ENABLE && !(atomic_ws && ws_run)
    |=> TX_ERROR_FLAG == !$past(par_ok))
    else $error("data-only parity result wrong");

  full_set_a: assert property (
    char_en && (PARITY_CHECK_SELECT == LVL_HIGH) && bypass && !PAB_ERROR
    && !(^{in_r.tx_data_bits, in_r.tx_control_bits, in_r.tx_parity_bit})
    |=> TX_ERROR_FLAG && (TX_CHAR == VIOL_POS))
    else $error("full-set parity error missed");

  bypass_pass_a: assert property (
    char_en && bypass && !PAB_ERROR && !par_err |=> TX_CHAR == $past(raw_char))
    else $error("bypass character altered");

  lsb_first_a: assert property (
    char_en |=> (SER_OUT == TX_CHAR[0]) ##3 (SER_OUT == TX_CHAR[3]))
    else $error("shifter order wrong");

  pab_viol_a: assert property (
    char_en && PAB_ERROR |=> TX_ERROR_FLAG && is_violation(TX_CHAR))
    else $error("buffer error without violation symbol");

  err_with_viol_a: assert property (
    TX_ERROR_FLAG |-> is_violation(TX_CHAR))
    else $error("error flag without violation symbol");

  atomic_len_a: assert property (
    @(posedge SYS_CLK) disable iff (!RSTN || PAB_ERROR)
    $rose(ws_run) && atomic_ws && !BIST_ENABLE
    |-> ##140 (ws_run && (ws_idx_r == WS_LAST_IDX)))
    else $error("atomic word sync cut short");

  intr_break_a: assert property (
    char_en && intr_ws && ws_run && par_err && !PAB_ERROR && !BIST_ENABLE
    |=> !ws_run && TX_ERROR_FLAG)
    else $error("parity error did not end word sync");

  bypass_viol_c: cover property (char_en && bypass && par_err);
  ws_start_c:    cover property ($rose(ws_run) && atomic_ws);
  intr_break_c:  cover property (char_en && intr_ws && ws_run && par_err);
  bist_c:        cover property (char_en && BIST_ENABLE && (lfsr_r == LFSR_SEED));

endmodule

// >>> pkg/tx_codec_pkg.sv
package tx_codec_pkg;

  // Three-level static select pins, resolved to two bits at the pad
  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } level_t;

  // Word sync sequencer
  typedef enum logic {
    WS_IDLE = 1'h0,
    WS_RUN  = 1'h1
  } ws_state_t;

  // Source of the next transmission character
  typedef enum logic [1:0] {
    OUT_ENC      = 2'h0,
    OUT_RAW      = 2'h1,
    OUT_VIOL_POS = 2'h2,
    OUT_VIOL_RD  = 2'h3
  } out_sel_t;

  // One character as presented by the host
  typedef struct packed {
    logic       special_code_select;
    logic       tx_parity_bit;
    logic [1:0] tx_control_bits;
    logic [7:0] tx_data_bits;
  } tx_char_in_t;

  // Request to the 8B/10B encoder
  typedef struct packed {
    logic [7:0] data;
    logic       is_k;
    logic       rd;
  } enc_req_t;

  // Character framing: one character every ten clocks, LSB first
  localparam logic [3:0]  BIT_CNT_LAST = 4'h9;
  localparam logic [3:0]  BIT_CNT_RST  = 4'h0;
  localparam logic [3:0]  WS_LAST_IDX  = 4'hF;
  localparam logic [3:0]  WS_FIRST_IDX = 4'h0;

  // Reset values; the held input carries good odd parity
  localparam tx_char_in_t IN_RESET     = 12'h400;
  localparam logic [9:0]  CHAR_RESET   = 10'h000;
  localparam logic        RD_RESET     = 1'h0;
  localparam logic [8:0]  LFSR_SEED    = 9'h1FF;

  // Fixed characters (bit 0 is the first bit on the line)
  localparam logic [9:0]  VIOL_POS     = 10'h079;
  localparam logic [7:0]  K28_5_CODE   = 8'hBC;
  localparam logic [4:0]  K28_X        = 5'h1C;

  // 5b/6b and 3b/4b codes, negative column, first line bit in the MSB
  localparam logic [5:0] SIX_B [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] FOUR_B [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [5:0] SIX_B_K28 = 6'h0F;
  localparam logic [5:0] SIX_B_D7  = 6'h38;
  localparam logic [3:0] FOUR_B_A7 = 4'h7;
  localparam logic [3:0] FOUR_B_X3 = 4'hC;

  // Second special table, indexed by the low three data bits
  localparam logic [7:0] REDUCED_SPECIAL [8] = '{
    8'hBC, 8'h3C, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE, 8'h1C};

  function automatic logic [2:0] count_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic is_violation(input logic [9:0] c);
    return (c == VIOL_POS) || (c == ~VIOL_POS);
  endfunction

endpackage
